// ### hdl/wwt_top.sv
// Windowed watchdog timer: registers, 24-bit down counter, window and underflow events.
// Assumes a plain register port on the system clock and an asynchronous RC oscillator pin.
// Function
// - Watchdog count is a 24-bit down counter readable by software.
// - Counter equal to window value raises an interrupt when enabled.
// - Underflow interval follows the software reload value.
// - Underflow in reset mode asserts an internal reset request.
// - Software selects whether underflow causes reset or periodic interrupt.
// - Interrupt mode makes it a repeating interval timer.
// - Counting runs on the dedicated RC oscillator with selectable count clock.
// - An output pulse marks each counter underflow.
`timescale 1ns/10ps
module wwt_top
	import wwt_pkg::*;
(
	// System
	input  wire logic              CLOCK,
	input  wire logic              NRST,
	// Oscillator pin
	input  wire logic              RC_OSC,
	// Register port
	input  wire logic [ADDR_W-1:0] ADDR,
	input  wire logic [DATA_W-1:0] WDATA,
	input  wire logic              WR,
	input  wire logic              RD,
	output logic      [DATA_W-1:0] RDATA,
	// Events
	output logic                   RESET_REQ,
	output logic                   IRQ,
	output logic                   OVF_OUT
);
	typedef struct packed {
		logic              en;
		logic              mode;
		logic              wie;
		logic              uie;
		logic [1:0]        csel;
		logic [CNT_W-1:0]  reload;
		logic [CNT_W-1:0]  window;
		logic [CNT_W-1:0]  cnt;
		logic              wflag;
		logic              uflag;
		logic              rst_req;
		logic              ovf;
		logic              irq;
		logic [DATA_W-1:0] rdata;
	} wwt_state_t;

	wwt_state_t st_r;
	wwt_state_t st_nxt;
	wwt_tick_if tk ();
	logic       tick;
	logic       udf;
	logic       win_hit;
	logic       load;

	wwt_tick u_tick (
		.CLOCK  (CLOCK),
		.NRST   (NRST),
		.rc_osc (RC_OSC),
		.tk     (tk)
	);

	assign tk.csel = st_r.csel;
	assign tick = tk.tick;
	assign load = WR && ((ADDR == OFS_COUNT) || (ADDR == OFS_CTRL && WDATA[CTRL_EN] && !st_r.en));
	assign udf = tick && st_r.en && !load && (st_r.cnt == '0);
	assign win_hit = tick && st_r.en && !load && (st_r.cnt != '0)
		&& ((st_r.cnt - 24'h1) == st_r.window);

	always_comb begin
		st_nxt = st_r;
		st_nxt.rdata = '0;
		if (WR) begin
			case (ADDR)
				OFS_CTRL: begin
					st_nxt.en = WDATA[CTRL_EN];
					st_nxt.mode = WDATA[CTRL_MODE];
					st_nxt.wie = WDATA[CTRL_WIE];
					st_nxt.uie = WDATA[CTRL_UIE];
					st_nxt.csel = WDATA[CTRL_CSEL_LO +: 2];
				end
				OFS_RELOAD: st_nxt.reload = WDATA[CNT_W-1:0];
				OFS_WINDOW: st_nxt.window = WDATA[CNT_W-1:0];
				OFS_STATUS: begin
					if (WDATA[STAT_WIN]) st_nxt.wflag = 1'b0;
					if (WDATA[STAT_UDF]) st_nxt.uflag = 1'b0;
				end
				default: ;
			endcase
		end
		// A write to the count register is the kick; it restarts from the reload value.
		if (load) begin
			st_nxt.cnt = st_r.reload;
		end else if (udf) begin
			st_nxt.cnt = st_r.reload;
		end else if (tick && st_r.en) begin
			st_nxt.cnt = st_r.cnt - 24'h1;
		end
		// Hardware sets are applied last, so an event beats a clear in the same cycle.
		if (win_hit) st_nxt.wflag = 1'b1;
		if (udf && st_r.mode) st_nxt.uflag = 1'b1;
		st_nxt.rst_req = udf && !st_r.mode;
		st_nxt.ovf = udf;
		st_nxt.irq = (st_nxt.wflag && st_nxt.wie) || (st_nxt.uflag && st_nxt.uie);
		if (RD) begin
			case (ADDR)
				OFS_CTRL: st_nxt.rdata = {26'h0, st_r.csel, st_r.uie, st_r.wie, st_r.mode, st_r.en};
				OFS_RELOAD: st_nxt.rdata = {8'h0, st_r.reload};
				OFS_WINDOW: st_nxt.rdata = {8'h0, st_r.window};
				OFS_COUNT: st_nxt.rdata = {8'h0, st_r.cnt};
				OFS_STATUS: st_nxt.rdata = {30'h0, st_r.uflag, st_r.wflag};
				default: st_nxt.rdata = '0;
			endcase
		end
	end

	always_ff @(posedge CLOCK or negedge NRST) begin
		if (!NRST) begin
			st_r <= '0;
			st_r.reload <= RELOAD_RST;
			st_r.window <= WINDOW_RST;
			st_r.csel <= CSEL_RST;
			st_r.cnt <= RELOAD_RST;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign RDATA = st_r.rdata;
	assign RESET_REQ = st_r.rst_req;
	assign IRQ = st_r.irq;
	assign OVF_OUT = st_r.ovf;

	sequence s_underflow;
		tick && st_r.en && !load && st_r.cnt == '0;
	endsequence

	property p_decrement;
		@(posedge CLOCK) disable iff (!NRST)
		tick && st_r.en && !load && st_r.cnt != '0 |=> st_r.cnt == $past(st_r.cnt) - 24'h1;
	endproperty
	a_decrement: assert property (p_decrement)
		else $error("Counter did not step down by one on a tick.");

	property p_window_irq;
		@(posedge CLOCK) disable iff (!NRST)
		win_hit && st_r.wie |=> IRQ && st_r.wflag;
	endproperty
	a_window_irq: assert property (p_window_irq)
		else $error("Window match with enable did not raise the interrupt.");

	property p_reload;
		@(posedge CLOCK) disable iff (!NRST)
		s_underflow |=> st_r.cnt == $past(st_r.reload);
	endproperty
	a_reload: assert property (p_reload)
		else $error("Underflow did not restart from the reload value.");

	property p_reset_req;
		@(posedge CLOCK) disable iff (!NRST)
		s_underflow ##0 !st_r.mode |=> RESET_REQ ##1 !RESET_REQ;
	endproperty
	a_reset_req: assert property (p_reset_req)
		else $error("Underflow in reset mode gave no one-cycle reset request.");

	property p_mode_int;
		@(posedge CLOCK) disable iff (!NRST)
		RESET_REQ |-> $past(udf) && !$past(st_r.mode);
	endproperty
	a_mode_int: assert property (p_mode_int)
		else $error("Reset request outside an underflow in reset mode.");

	property p_interval_irq;
		@(posedge CLOCK) disable iff (!NRST)
		s_underflow ##0 st_r.mode && st_r.uie |=> IRQ && !RESET_REQ;
	endproperty
	a_interval_irq: assert property (p_interval_irq)
		else $error("Interval underflow did not raise the interrupt.");

	property p_count_hold;
		@(posedge CLOCK) disable iff (!NRST)
		!tick && !load |=> $stable(st_r.cnt);
	endproperty
	a_count_hold: assert property (p_count_hold)
		else $error("Counter moved without a count tick or load.");

	property p_ovf;
		@(posedge CLOCK) disable iff (!NRST)
		s_underflow |=> OVF_OUT ##1 !OVF_OUT;
	endproperty
	a_ovf: assert property (p_ovf)
		else $error("Underflow output pulse missing or too long.");

	property p_irq_sync;
		@(posedge CLOCK) disable iff (!NRST)
		IRQ |-> (st_r.wflag && st_r.wie) || (st_r.uflag && st_r.uie);
	endproperty
	a_irq_sync: assert property (p_irq_sync)
		else $error("Interrupt output not backed by an enabled flag.");

	property p_kick_reload;
		@(posedge CLOCK) disable iff (!NRST)
		load |=> st_r.cnt == $past(st_r.reload);
	endproperty
	a_kick_reload: assert property (p_kick_reload)
		else $error("Kick or enable did not load the reload value.");

	property p_window_flag;
		@(posedge CLOCK) disable iff (!NRST)
		win_hit |=> st_r.wflag;
	endproperty
	a_window_flag: assert property (p_window_flag)
		else $error("Window match did not set the window flag.");

	property p_count_read;
		@(posedge CLOCK) disable iff (!NRST)
		RD && ADDR == OFS_COUNT |=> RDATA == {8'h00, $past(st_r.cnt)};
	endproperty
	a_count_read: assert property (p_count_read)
		else $error("Count read did not return the counter value.");

	property p_rdata_idle;
		@(posedge CLOCK) disable iff (!NRST)
		!RD |=> RDATA == '0;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle)
		else $error("Read data not zero outside the read answer cycle.");

	property p_udf_no_flag;
		@(posedge CLOCK) disable iff (!NRST)
		s_underflow ##0 !st_r.mode |=> !$rose(st_r.uflag);
	endproperty
	a_udf_no_flag: assert property (p_udf_no_flag)
		else $error("Underflow in reset mode set the underflow flag.");
endmodule

// ### hdl/wwt_pkg.sv
// Constants for the windowed watchdog timer: register map, fields and reset values.
// Assumes a single system clock and a plain register port with byte addresses.
package wwt_pkg;
	localparam int          CNT_W        = 24;
	localparam int          ADDR_W       = 8;
	localparam int          DATA_W       = 32;
	localparam int          PRE_W        = 3;
	localparam logic [7:0]  OFS_CTRL     = 8'h00;
	localparam logic [7:0]  OFS_RELOAD   = 8'h04;
	localparam logic [7:0]  OFS_WINDOW   = 8'h08;
	localparam logic [7:0]  OFS_COUNT    = 8'h0c;
	localparam logic [7:0]  OFS_STATUS   = 8'h10;
	localparam int          CTRL_EN      = 0;
	localparam int          CTRL_MODE    = 1;
	localparam int          CTRL_WIE     = 2;
	localparam int          CTRL_UIE     = 3;
	localparam int          CTRL_CSEL_LO = 4;
	localparam int          STAT_WIN     = 0;
	localparam int          STAT_UDF     = 1;
	localparam logic [23:0] RELOAD_RST   = 24'hffffff;
	localparam logic [23:0] WINDOW_RST   = 24'h000000;
	localparam logic [1:0]  CSEL_RST     = 2'h0;
endpackage

// ### hdl/wwt_tick_if.sv
// Carries the count clock selection to the tick generator and the count tick back.
// Assumes both ends run on the system clock.
`timescale 1ns/10ps
interface wwt_tick_if;
	logic [1:0] csel;
	logic       tick;
	modport src (input csel, output tick);
	modport snk (output csel, input tick);
endinterface

// ### hdl/wwt_tick.sv
// Count tick generator: samples the dedicated RC oscillator and divides its edges.
// Assumes the oscillator is far slower than the system clock and arrives asynchronously.
`timescale 1ns/10ps
module wwt_tick
	import wwt_pkg::*;
(
	// System
	input  wire logic CLOCK,
	input  wire logic NRST,
	// Oscillator pin
	input  wire logic rc_osc,
	// Tick link
	wwt_tick_if.src   tk
);
	typedef struct packed {
		logic             s1;
		logic             s2;
		logic             prev;
		logic [PRE_W-1:0] pre;
		logic             tick;
	} wwt_tick_st_t;

	wwt_tick_st_t st_r;
	wwt_tick_st_t st_nxt;
	logic [PRE_W-1:0] mask;

	always_comb begin
		st_nxt = st_r;
		mask = PRE_W'((4'h1 << tk.csel) - 4'h1);
		// Only the second stage feeds the edge detect, so metastability stays contained.
		st_nxt.s1 = rc_osc;
		st_nxt.s2 = st_r.s1;
		st_nxt.prev = st_r.s2;
		st_nxt.tick = 1'b0;
		if (st_r.s2 && !st_r.prev) begin
			st_nxt.pre = st_r.pre + 3'h1;
			st_nxt.tick = ((st_r.pre & mask) == mask);
		end
	end

	always_ff @(posedge CLOCK or negedge NRST) begin
		if (!NRST) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign tk.tick = st_r.tick;

	property p_tick_from_edge;
		@(posedge CLOCK) disable iff (!NRST)
		tk.tick |-> $past(st_r.s2) && !$past(st_r.prev);
	endproperty
	a_tick_from_edge: assert property (p_tick_from_edge)
		else $error("Count tick without a synchronised oscillator edge.");

	property p_tick_single;
		@(posedge CLOCK) disable iff (!NRST)
		tk.tick |=> !tk.tick;
	endproperty
	a_tick_single: assert property (p_tick_single)
		else $error("Count tick lasted more than one cycle.");
endmodule

// ### dv/tb.sv
// Self-checking bench for the windowed watchdog timer, driving its register port directly.
// Assumes a slow RC oscillator pin toggled by the bench and a 200 MHz system clock.
`timescale 1ns/10ps
module tb
	import wwt_pkg::*;
;
	logic              CLOCK, NRST, RC_OSC, WR, RD, RESET_REQ, IRQ, OVF_OUT;
	logic [ADDR_W-1:0] ADDR;
	logic [DATA_W-1:0] WDATA, RDATA;
	int                bad_count, checked, ovf_seen, rreq_seen;

	wwt_top dut_u (.CLOCK(CLOCK), .NRST(NRST), .RC_OSC(RC_OSC), .ADDR(ADDR), .WDATA(WDATA),
		.WR(WR), .RD(RD), .RDATA(RDATA), .RESET_REQ(RESET_REQ), .IRQ(IRQ), .OVF_OUT(OVF_OUT));

	initial begin
		CLOCK = 1'b0;
		forever #2.5 CLOCK = ~CLOCK;
	end

	// Event pulses last one cycle, so they are counted rather than sampled once.
	always @(posedge CLOCK) begin
		if (OVF_OUT === 1'b1) ovf_seen++;
		if (RESET_REQ === 1'b1) rreq_seen++;
	end

	task automatic end_sim();
		$display("checks %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask

	task automatic chk_word(string what, logic [31:0] exp, logic [31:0] got);
		checked++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic chk_bit(string what, logic exp, logic got);
		checked++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] %s expected %b seen %b", what, exp, got);
		end
	endtask

	task automatic wr(logic [7:0] a, logic [31:0] d);
		@(posedge CLOCK);
		WR <= 1'b1;
		ADDR <= a;
		WDATA <= d;
		@(posedge CLOCK);
		WR <= 1'b0;
	endtask

	task automatic rd(logic [7:0] a, logic [31:0] exp, string what);
		@(posedge CLOCK);
		RD <= 1'b1;
		ADDR <= a;
		@(posedge CLOCK);
		RD <= 1'b0;
		#1;
		chk_word(what, exp, RDATA);
	endtask

	// n slow oscillator periods of 17 cycles each; long enough for the synchroniser and tick to settle.
	task automatic rc_edges(int n);
		repeat (n) begin
			@(posedge CLOCK);
			RC_OSC <= 1'b1;
			repeat (8) @(posedge CLOCK);
			RC_OSC <= 1'b0;
			repeat (8) @(posedge CLOCK);
		end
	endtask

	initial begin
		#(5ns * 20000);
		bad_count++;
		end_sim();
	end

	initial begin
		NRST = 1'b0;
		RC_OSC = 1'b0;
		WR = 1'b0;
		RD = 1'b0;
		ADDR = 8'h00;
		WDATA = 32'h00000000;
		repeat (10) @(posedge CLOCK);
		NRST <= 1'b1;
		rd(OFS_CTRL, 32'h00000000, "ctrl");
		rd(OFS_RELOAD, {8'h00, RELOAD_RST}, "reload");
		rd(OFS_WINDOW, {8'h00, WINDOW_RST}, "window");
		rd(OFS_COUNT, 32'h00ffffff, "count");
		@(posedge CLOCK);
		#1;
		chk_word("rdata idle", 32'h00000000, RDATA);
		rd(OFS_STATUS, 32'h00000000, "status");
		rd(8'h14, 32'h00000000, "unmapped");
		$display("test reset done");

		// Interrupt mode: window hit, underflow, then the cycle repeats.
		wr(OFS_RELOAD, 32'hff000003);
		rd(OFS_RELOAD, 32'h00000003, "reload upper");
		wr(OFS_WINDOW, 32'h00000001);
		wr(OFS_CTRL, 32'h0000000f);
		rd(OFS_CTRL, 32'h0000000f, "ctrl");
		rd(OFS_COUNT, 32'h00000003, "count load");
		rc_edges(2);
		rd(OFS_COUNT, 32'h00000001, "count down");
		rd(OFS_STATUS, 32'h00000001, "window flag");
		chk_bit("irq window", 1'b1, IRQ);
		wr(OFS_STATUS, 32'h00000001);
		repeat (2) @(posedge CLOCK);
		#1;
		chk_bit("irq cleared", 1'b0, IRQ);
		rc_edges(2);
		rd(OFS_COUNT, 32'h00000003, "count reload");
		rd(OFS_STATUS, 32'h00000002, "underflow flag");
		chk_bit("irq underflow", 1'b1, IRQ);
		chk_word("ovf pulses", 32'h1, ovf_seen);
		chk_word("no reset req", 32'h0, rreq_seen);
		rc_edges(2);
		rd(OFS_STATUS, 32'h00000003, "window again");
		$display("test interrupt mode done");

		// Reset mode: underflow requests a reset and sets no interrupt.
		wr(OFS_CTRL, 32'h00000000);
		wr(OFS_STATUS, 32'h00000003);
		wr(OFS_RELOAD, 32'h00000001);
		wr(OFS_WINDOW, 32'h00000000);
		wr(OFS_CTRL, 32'h00000001);
		rc_edges(2);
		chk_word("reset req", 32'h1, rreq_seen);
		chk_word("ovf pulses", 32'h2, ovf_seen);
		chk_bit("irq reset mode", 1'b0, IRQ);
		rd(OFS_COUNT, 32'h00000001, "count reload");
		$display("test reset mode done");

		// Each count clock divider takes exactly 2^sel oscillator edges per step.
		wr(OFS_RELOAD, 32'h00000100);
		for (int s = 0; s < 4; s++) begin
			wr(OFS_CTRL, 32'h00000001 | (s << 4));
			wr(OFS_COUNT, 32'h00000000);
			rc_edges(2 << s);
			rd(OFS_COUNT, 32'h000000fe, "divided count");
		end
		$display("test clock select done");

		// A reset in mid-run must bring back the power-up values.
		@(posedge CLOCK);
		NRST <= 1'b0;
		repeat (2) @(posedge CLOCK);
		NRST <= 1'b1;
		rd(OFS_COUNT, {8'h00, RELOAD_RST}, "count after reset");
		rd(OFS_CTRL, 32'h00000000, "ctrl after reset");
		chk_word("reset req total", 32'h1, rreq_seen);
		$display("test mid-run reset done");
		end_sim();
	end
endmodule
